// file: shared/tsu_pkg.sv
// What this block does
// RULE_01 - Four-bit selector routes pin 0..11 to the unit; codes 12..15 select nothing.
// RULE_02 - Rising-edge enable makes low-to-high transitions count as events.
// RULE_03 - Falling-edge enable makes high-to-low transitions count as events.
// RULE_04 - Tail bit marks this unit as last of a cascade chain.
// RULE_05 - Four-bit field picks which unit supplies the upstream done input.
// RULE_06 - Software programs head unit with zero, followers with predecessor number.
// RULE_07 - Cascade-enable bit selects cascade or standalone operation.
// RULE_08 - First event nanoseconds bits 15..0 readable, 40 ns resolution.
// RULE_09 - First event nanoseconds bits 29..16 in low 14 bits; top bit reserved.
// RULE_10 - Bit 14 of nanoseconds high word holds edge polarity, one means rising.
// RULE_11 - First event seconds bits 15..0 readable.
// RULE_12 - First event seconds bits 31..16 readable in separate word.
// RULE_13 - Three-bit sub-slot code gives 8 ns slot of first event.
// RULE_14 - Configuration and capture fields reset to zero; reserved bits read zero.
// RULE_15 - Enable bit: setting clears event count, clearing clears ready and overflow.
// RULE_16 - Standalone unit counts up to 15 edges at rates up to 25 MHz.
// RULE_17 - All first-sample fields latch together on the first enabled edge.
package tsu_pkg;
	// Register indices; byte address is four times the index
	localparam logic [10:0] IDX_ENABLE = 11'h402;
	localparam logic [10:0] IDX_STATUS = 11'h420;
	localparam logic [10:0] IDX_CONFIG = 11'h422;
	localparam logic [10:0] IDX_NS_LOW = 11'h424;
	localparam logic [10:0] IDX_NS_HIGH = 11'h426;
	localparam logic [10:0] IDX_SEC_LOW = 11'h428;
	localparam logic [10:0] IDX_SEC_HIGH = 11'h42a;
	localparam logic [10:0] IDX_SUBSLOT = 11'h42c;
	localparam logic [10:0] IDX_IRQ_STATUS = 11'h430;
	localparam logic [10:0] IDX_IRQ_MASK = 11'h431;
	localparam int ADDR_W = 13;
	// Field positions
	localparam int CFG_CASCADE = 0;
	localparam int CFG_UP_LSB = 1;
	localparam int CFG_TAIL = 5;
	localparam int CFG_FALL = 6;
	localparam int CFG_RISE = 7;
	localparam int CFG_PIN_LSB = 8;
	localparam logic [15:0] CFG_WMASK = 16'h0fff;
	localparam int NSH_EDGE = 14;
	localparam int IRQ_CAPTURE = 0;
	localparam int IRQ_OVERFLOW = 1;
	// Sizes and limits
	localparam int PIN_COUNT = 12;
	localparam logic [3:0] PIN_LAST = 4'hb;
	localparam logic [3:0] COUNT_MAX = 4'hf;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing figures of the time base
	localparam int NS_RESOLUTION_NS = 40;
	localparam int SUBSLOT_NS = 8;
	localparam int SUBSLOT_COUNT = NS_RESOLUTION_NS / SUBSLOT_NS;

	// Time of day as delivered by the timing logic
	typedef struct packed {
		logic [31:0] sec;
		logic [29:0] ns;
		logic [2:0] sub;
	} tsu_time_type;

	// One first-sample record
	typedef struct packed {
		tsu_time_type at;
		logic rising;
	} tsu_capture_type;
endpackage

// file: rtl/tsu_capture_unit.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tsu_capture_unit
	import tsu_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pins, system time and upstream done
	input wire logic [PIN_COUNT-1:0] gpio_i,
	input wire tsu_time_type time_i,
	input wire logic [PIN_COUNT-1:0] upstream_done_i,
	// Chain and interrupt
	output logic done_o,
	output logic irq_o,
	// AXI4-Lite write address
	input wire logic awvalid_i,
	input wire logic [ADDR_W-1:0] awaddr_i,
	output logic awready_o,
	// AXI4-Lite write data
	input wire logic wvalid_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	output logic wready_o,
	// AXI4-Lite write response
	output logic bvalid_o,
	output logic [1:0] bresp_o,
	input wire logic bready_i,
	// AXI4-Lite read address
	input wire logic arvalid_i,
	input wire logic [ADDR_W-1:0] araddr_i,
	output logic arready_o,
	// AXI4-Lite read data
	output logic rvalid_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	input wire logic rready_i
);
	logic [PIN_COUNT-1:0] sync1;
	logic [PIN_COUNT-1:0] sync2;
	logic [PIN_COUNT-1:0] sync3;
	logic [PIN_COUNT-1:0] level;
	logic [15:0] config_reg;
	logic unit_enable;
	logic [3:0] event_count;
	logic overflow;
	logic captured;
	tsu_capture_type first;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// Pin synchroniser; sync1 feeds only sync2
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= gpio_i;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Filtered level per pin, moves only when two stages agree
	logic [PIN_COUNT-1:0] rise_pin;
	logic [PIN_COUNT-1:0] fall_pin;
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : pin_filter
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					level[g] <= 1'b0;
				end else if (sync2[g] == sync3[g]) begin
					level[g] <= sync3[g];
				end
			end
			assign rise_pin[g] = (sync2[g] == sync3[g]) && sync3[g] && !level[g];
			assign fall_pin[g] = (sync2[g] == sync3[g]) && !sync3[g] && level[g];
		end
	endgenerate

	// Pin selection; unused codes watch nothing
	logic [3:0] pin_sel;
	logic pin_valid;
	logic sel_rise;
	logic sel_fall;
	assign pin_sel = config_reg[CFG_PIN_LSB +: 4];
	assign pin_valid = pin_sel <= PIN_LAST; // RULE_01
	assign sel_rise = pin_valid && rise_pin[pin_sel[3:0] <= PIN_LAST ? pin_sel : 4'h0]; // RULE_01
	assign sel_fall = pin_valid && fall_pin[pin_sel[3:0] <= PIN_LAST ? pin_sel : 4'h0]; // RULE_01

	// Cascade gating: zero in the upstream field is the head and needs no done
	logic [3:0] up_sel;
	logic armed;
	assign up_sel = config_reg[CFG_UP_LSB +: 4];
	always_comb begin
		armed = 1'b1;
		if (config_reg[CFG_CASCADE]) begin // RULE_07
			if (up_sel != 4'h0 && up_sel <= PIN_LAST) begin // RULE_05 RULE_06
				armed = upstream_done_i[up_sel - 4'h1];
			end else if (up_sel > PIN_LAST) begin
				armed = 1'b0;
			end
		end
	end

	// An accepted event, one cycle per filtered edge
	logic take_rise;
	logic take_fall;
	logic event_hit;
	assign take_rise = config_reg[CFG_RISE] && sel_rise; // RULE_02
	assign take_fall = config_reg[CFG_FALL] && sel_fall; // RULE_03
	assign event_hit = unit_enable && armed && (take_rise || take_fall); // RULE_16

	// Bus write decode, done once both halves are held
	logic wr_fire;
	logic [10:0] wr_idx;
	logic wr_hit;
	logic [15:0] wr_word;
	assign wr_fire = aw_held && w_held && !bvalid_o;
	assign wr_idx = aw_addr[ADDR_W-1:2];
	assign wr_word = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};
	always_comb begin
		if (wr_idx == IDX_ENABLE || wr_idx == IDX_CONFIG) begin
			wr_hit = 1'b1;
		end else if (wr_idx == IDX_IRQ_STATUS || wr_idx == IDX_IRQ_MASK) begin
			wr_hit = 1'b1;
		end else if (wr_idx == IDX_STATUS || wr_idx == IDX_NS_LOW || wr_idx == IDX_NS_HIGH) begin
			wr_hit = 1'b1;
		end else if (wr_idx == IDX_SEC_LOW || wr_idx == IDX_SEC_HIGH || wr_idx == IDX_SUBSLOT) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end
	logic en_write;
	assign en_write = wr_fire && wr_idx == IDX_ENABLE && w_strb[0];

	// Configuration register; reserved bits never stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			config_reg <= RESET_WORD; // RULE_14
		end else if (wr_fire && wr_idx == IDX_CONFIG) begin
			config_reg <= (config_reg & ~({{8{w_strb[1]}}, {8{w_strb[0]}}})) |
				(wr_word & CFG_WMASK); // RULE_14
		end
	end

	// Unit enable, count, overflow; re-enabling restarts the count so the next edge is first again
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unit_enable <= 1'b0;
			event_count <= 4'h0;
			overflow <= 1'b0;
			captured <= 1'b0;
		end else if (en_write) begin
			unit_enable <= wr_word[0];
			if (wr_word[0]) begin
				event_count <= 4'h0; // RULE_15
			end else begin
				overflow <= 1'b0; // RULE_15
				captured <= 1'b0; // RULE_15
			end
		end else if (event_hit) begin
			captured <= 1'b1;
			if (event_count == COUNT_MAX) begin
				overflow <= 1'b1; // RULE_16
			end else begin
				event_count <= event_count + 4'h1; // RULE_16
			end
		end
	end

	// First sample: every field from the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first <= '0; // RULE_14
		end else if (event_hit && event_count == 4'h0) begin
			first.at <= time_i; // RULE_17 RULE_13
			first.rising <= take_rise; // RULE_10
		end
	end

	// Done towards the next unit; a tail has nobody downstream
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= config_reg[CFG_CASCADE] && !config_reg[CFG_TAIL] && captured; // RULE_04
		end
	end

	// Sticky interrupt bits; a new event beats a write-one-to-clear
	logic [1:0] irq_set;
	logic [1:0] irq_clr;
	logic [1:0] next_irq_mask;
	assign irq_set = {event_hit && event_count == COUNT_MAX, event_hit && event_count == 4'h0};
	assign irq_clr = (wr_fire && wr_idx == IDX_IRQ_STATUS && w_strb[0]) ? wr_word[1:0] : 2'h0;
	// Mask seen by the output is the one stored this edge, so a mask change never lags a cycle
	assign next_irq_mask = (wr_fire && wr_idx == IDX_IRQ_MASK && w_strb[0]) ? wr_word[1:0] : irq_mask;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status <= 2'h0;
			irq_mask <= 2'h0;
			irq_o <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			irq_mask <= next_irq_mask;
			irq_o <= |(((irq_status & ~irq_clr) | irq_set) & next_irq_mask);
		end
	end

	// Write channel: address and data taken in either order, one write at a time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= 4'h0;
			awready_o <= 1'b0;
			wready_o <= 1'b0;
			bvalid_o <= 1'b0;
			bresp_o <= RESP_OKAY;
		end else begin
			awready_o <= !aw_held && !(awvalid_i && awready_o) && !bvalid_o;
			wready_o <= !w_held && !(wvalid_i && wready_o) && !bvalid_o;
			if (awvalid_i && awready_o) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr_i;
			end
			if (wvalid_i && wready_o) begin
				w_held <= 1'b1;
				w_data <= wdata_i;
				w_strb <= wstrb_i;
			end
			if (wr_fire) begin
				bvalid_o <= 1'b1;
				bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end else if (bvalid_o && bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end

	// Read data mux; reserved bits come back as zero
	logic [10:0] rd_idx;
	logic [31:0] next_rdata;
	logic rd_hit;
	assign rd_idx = araddr_i[ADDR_W-1:2];
	always_comb begin
		next_rdata = 32'h0000_0000;
		rd_hit = 1'b1;
		if (rd_idx == IDX_ENABLE) begin
			next_rdata[0] = unit_enable;
		end else if (rd_idx == IDX_STATUS) begin
			next_rdata[4:0] = {event_count, overflow};
		end else if (rd_idx == IDX_CONFIG) begin
			next_rdata[15:0] = config_reg;
		end else if (rd_idx == IDX_NS_LOW) begin
			next_rdata[15:0] = first.at.ns[15:0]; // RULE_08
		end else if (rd_idx == IDX_NS_HIGH) begin
			next_rdata[NSH_EDGE] = first.rising; // RULE_10
			next_rdata[13:0] = first.at.ns[29:16]; // RULE_09
		end else if (rd_idx == IDX_SEC_LOW) begin
			next_rdata[15:0] = first.at.sec[15:0]; // RULE_11
		end else if (rd_idx == IDX_SEC_HIGH) begin
			next_rdata[15:0] = first.at.sec[31:16]; // RULE_12
		end else if (rd_idx == IDX_SUBSLOT) begin
			next_rdata[2:0] = first.at.sub; // RULE_13
		end else if (rd_idx == IDX_IRQ_STATUS) begin
			next_rdata[1:0] = irq_status;
		end else if (rd_idx == IDX_IRQ_MASK) begin
			next_rdata[1:0] = irq_mask;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arready_o <= 1'b0;
			rvalid_o <= 1'b0;
			rdata_o <= 32'h0000_0000;
			rresp_o <= RESP_OKAY;
		end else begin
			arready_o <= !rvalid_o && !(arvalid_i && arready_o);
			if (arvalid_i && arready_o) begin
				rvalid_o <= 1'b1;
				rdata_o <= next_rdata;
				rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_o && rready_i) begin
				rvalid_o <= 1'b0;
			end
		end
	end

	// Checks
	first_latch_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
		event_hit && event_count == 4'h0 |=> first.at == $past(time_i) && first.rising == $past(take_rise))
		else $error("first sample not latched as one record");
	first_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
		event_count != 4'h0 && !en_write |=> $stable(first))
		else $error("first sample changed after first event");
	bad_pin_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
		pin_sel > PIN_LAST |-> !event_hit)
		else $error("event taken with unused pin code");
	edge_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
		event_hit |-> (config_reg[CFG_RISE] && sel_rise) || (config_reg[CFG_FALL] && sel_fall))
		else $error("event taken without matching enabled edge");
	count_sat_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
		event_hit && event_count == COUNT_MAX && !en_write |=> event_count == COUNT_MAX && overflow)
		else $error("count did not saturate with overflow");
	enable_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
		en_write && !wr_word[0] |=> !overflow && !captured ##1 !done_o)
		else $error("disable did not clear ready and overflow");
	reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
		config_reg[15:12] == 4'h0 && (!rvalid_o || rdata_o[31:16] == 16'h0000))
		else $error("reserved configuration bits set");
	irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == |(irq_status & irq_mask))
		else $error("interrupt low with unmasked status");
	write_resp_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_fire |=> bvalid_o && bresp_o == (($past(wr_hit)) ? RESP_OKAY : RESP_SLVERR))
		else $error("write response missing or wrong");
	tail_done_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
		config_reg[CFG_TAIL] && $past(config_reg[CFG_TAIL]) |-> !done_o)
		else $error("tail unit raised done");
endmodule

// file: sim/tsu_pin_model.sv
`timescale 1ns/1ps
// Far side: the selected pin toggles on command, the others chatter as noise
module tsu_pin_model
	import tsu_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Commands
	input wire logic [3:0] sel_i,
	input wire logic toggle_i,
	input wire logic noise_i,
	// Pins
	output logic [PIN_COUNT-1:0] gpio_o
);
	logic ph = 1'b0;
	logic [PIN_COUNT-1:0] pin_q = '0;
	assign gpio_o = pin_q;
	// Noise moves every other cycle so no pin runs faster than the unit resolves
	always @(posedge clk_i) begin
		ph <= ~ph;
		for (int k = 0; k < PIN_COUNT; k++) begin
			if (k == sel_i) begin
				if (toggle_i) pin_q[k] <= ~pin_q[k];
			end else if (noise_i && ph) begin
				pin_q[k] <= ~pin_q[k];
			end
		end
	end
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
	import tsu_pkg::*;
	logic clk_i = 0, rst_i = 1;
	logic [PIN_COUNT-1:0] gpio_i, upstream_done_i = '0, lvl = '0;
	tsu_time_type time_i = '0;
	logic done_o, irq_o, awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
	logic awvalid_i = 0, wvalid_i = 0, bready_i = 1, arvalid_i = 0, rready_i = 1;
	logic [ADDR_W-1:0] awaddr_i = '0, araddr_i = '0;
	logic [31:0] wdata_i = '0, rdata_o, lf = 32'h5eb8;
	logic [3:0] wstrb_i = '0, sel = '0, cnt;
	logic [1:0] bresp_o, rresp_o;
	logic tog = 0, noise = 0, ovf, fst;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int miscompares = 0, checks = 0;
	tsu_capture_type cap = '0;
	logic [10:0] regs [10] = '{IDX_ENABLE, IDX_STATUS, IDX_CONFIG, IDX_NS_LOW, IDX_NS_HIGH, IDX_SEC_LOW,
		IDX_SEC_HIGH, IDX_SUBSLOT, IDX_IRQ_STATUS, IDX_IRQ_MASK};
	always #12.5 clk_i = ~clk_i;
	tsu_capture_unit uut (.clk_i, .rst_i, .gpio_i, .time_i, .upstream_done_i, .done_o, .irq_o, .awvalid_i,
		.awaddr_i, .awready_o, .wvalid_i, .wdata_i, .wstrb_i, .wready_o, .bvalid_o, .bresp_o, .bready_i,
		.arvalid_i, .araddr_i, .arready_o, .rvalid_o, .rdata_o, .rresp_o, .rready_i);
	tsu_pin_model pins (.clk_i, .sel_i(sel), .toggle_i(tog), .noise_i(noise), .gpio_o(gpio_i));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done();
		if (miscompares == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Each channel holds until its own handshake; ready lines stay high throughout
	task automatic wr(input logic [10:0] i, input logic [15:0] d, input logic [1:0] e = RESP_OKAY);
		bit b;
		b = 0;
		bq.push_back(e);
		awvalid_i <= 1;
		wvalid_i <= 1;
		awaddr_i <= {i, 2'b00};
		wdata_i <= {lf[31:16], d};
		wstrb_i <= 4'h3;
		while (!b) begin
			@(posedge clk_i);
			if (awready_o) awvalid_i <= 0;
			if (wready_o) wvalid_i <= 0;
			b = bvalid_o;
		end
	endtask
	task automatic rd(input logic [10:0] i, input logic [15:0] d, input logic [1:0] e = RESP_OKAY);
		bit b;
		b = 0;
		rq.push_back({e, 16'h0, d});
		arvalid_i <= 1;
		araddr_i <= {i, 2'b00};
		while (!b) begin
			@(posedge clk_i);
			if (arready_o) arvalid_i <= 0;
			b = rvalid_o;
		end
	endtask
	// Responses are matched against the oldest note as they appear
	always @(posedge clk_i) begin
		if (bvalid_o && bready_i) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp_o});
		if (rvalid_o && rready_i) chk("rdata", rq.pop_front(), {rresp_o, rdata_o});
	end
	// One edge on the selected pin; time is held long enough to be latched
	task automatic edge1(input logic [7:0] c);
		tsu_time_type t;
		logic hit;
		// Noise may have moved this pin while it was unselected; start from what it shows
		lvl = gpio_i;
		lf = lfsr(lf);
		t = {lf, ~lf[29:0], 3'(lf % 5)};
		time_i <= t;
		tog <= 1;
		noise <= 1;
		@(posedge clk_i);
		tog <= 0;
		hit = sel <= PIN_LAST && (lvl[sel] ? c[6] : c[7]) && (!c[0] || c[4:1] == 0
			|| (c[4:1] <= PIN_LAST && upstream_done_i[c[4:1] - 1]));
		if (hit && !fst) cap = {t, !lvl[sel]};
		if (hit) fst = 1;
		if (hit && cnt == COUNT_MAX) ovf = 1;
		if (hit && cnt != COUNT_MAX) cnt++;
		if (sel <= PIN_LAST) lvl[sel] = !lvl[sel];
		repeat (8) @(posedge clk_i);
		noise <= 0;
		@(posedge clk_i);
	endtask
	task automatic run(input logic [3:0] p, input logic [7:0] c, input int n);
		wr(IDX_ENABLE, 16'h0);
		wr(IDX_ENABLE, 16'h1);
		wr(IDX_IRQ_STATUS, 16'h3);
		sel <= p;
		upstream_done_i <= lf[11:0];
		wr(IDX_CONFIG, {4'h0, p, c});
		cnt = 0;
		ovf = 0;
		fst = 0;
		repeat (n) edge1(c);
		chk("done", done_o, c[0] && !c[5] && fst);
		chk("irq", irq_o, fst);
		rd(IDX_NS_LOW, cap.at.ns[15:0]);
		rd(IDX_NS_HIGH, {1'b0, cap.rising, cap.at.ns[29:16]});
		rd(IDX_SEC_LOW, cap.at.sec[15:0]);
		rd(IDX_SEC_HIGH, cap.at.sec[31:16]);
		rd(IDX_SUBSLOT, {13'h0, cap.at.sub});
		rd(IDX_STATUS, {11'h0, cnt, ovf});
		rd(IDX_IRQ_STATUS, {14'h0, ovf, fst});
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		repeat (2) @(posedge clk_i);
		foreach (regs[k]) rd(regs[k], RESET_WORD);
		chk("irq", irq_o, 0);
		wr(IDX_CONFIG, 16'hffff);
		rd(IDX_CONFIG, CFG_WMASK);
		wr(IDX_NS_HIGH, 16'h7fff);
		rd(IDX_NS_HIGH, 16'h0);
		wr(11'h42e, 16'h1, RESP_SLVERR);
		rd(11'h42e, 16'h0, RESP_SLVERR);
		wr(IDX_IRQ_MASK, 16'h1);
		run(4'h0, 8'h80, 2);
		run(4'hb, 8'h40, 2);
		run(4'h5, 8'h00, 2);
		run(4'hc, 8'hc0, 2);
		run(4'h7, 8'hc0, 16);
		// Only the overflow source is left unmasked
		wr(IDX_IRQ_MASK, 16'h2);
		wr(IDX_IRQ_STATUS, 16'h1);
		repeat (2) @(posedge clk_i);
		chk("irq", irq_o, 1);
		wr(IDX_IRQ_STATUS, 16'h2);
		repeat (2) @(posedge clk_i);
		chk("irq", irq_o, 0);
		wr(IDX_IRQ_MASK, 16'h1);
		run(4'h3, 8'hc1, 2);
		run(4'h9, 8'he1, 2);
		// Every nonzero upstream code, 1 to 15, a follower naming its predecessor among them
		for (int u = 1; u < 16; u++) run(4'h2, {3'b110, 4'(u), 1'b1}, 1);
		test_done();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (30000) @(posedge clk_i);
		miscompares++;
		test_done();
	end
endmodule
